// file: dv/rbg_air_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// air receive path model
// ---------------------------------------------------------------
module rbg_air_model (
    input  wire logic       hclk,
    output logic            rx_sync_word_valid,
    output logic      [7:0] rx_sync_word,
    output logic            rx_header_valid,
    output logic            rx_frame_done,
    output logic            rx_fcs_ok,
    output logic            rx_byte_valid,
    output logic      [7:0] rx_byte
);
    // idle state, all pulses low
    initial begin
        rx_sync_word_valid = 1'b0;
        rx_sync_word = 8'h00;
        rx_header_valid = 1'b0;
        rx_frame_done = 1'b0;
        rx_fcs_ok = 1'b0;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
    end

    // delimiter, header, payload bytes, then end with check result
    task automatic send(input logic [7:0] d, input int n, input logic ok);
        @(posedge hclk);
        rx_sync_word_valid <= 1'b1;
        rx_sync_word <= d;
        @(posedge hclk);
        rx_sync_word_valid <= 1'b0;
        rx_sync_word <= ~d; // stale word never left standing
        rx_header_valid <= 1'b1;
        @(posedge hclk);
        rx_header_valid <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            rx_byte_valid <= 1'b1;
            rx_byte <= 8'h10 + 8'(i);
            @(posedge hclk);
            rx_byte_valid <= 1'b0;
            rx_byte <= 8'hef - 8'(i); // inverse of last byte
        end
        @(posedge hclk);
        rx_frame_done <= 1'b1;
        rx_fcs_ok <= ok;
        @(posedge hclk);
        rx_frame_done <= 1'b0;
        rx_fcs_ok <= ~ok;
    endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, psdu_rate_select;
    logic [2:0]  hsize;
    logic        spi_sel_n, spi_fb_read, listen_state, auto_ack_receive_state;
    logic        tx_preamble_done, tx_bit_tick, host_fb_we;
    logic [6:0]  host_fb_addr, fb_addr, last_fa;
    logic [7:0]  host_fb_wdata, fb_wdata, rx_sync_word, rx_byte, d, last_fb;
    logic        rx_sync_word_valid, rx_header_valid, rx_frame_done;
    logic        rx_fcs_ok, rx_byte_valid, fb_we, air_wr_en, buf_protected;
    logic        frame_start_irq, frame_end_irq, tx_delim_bit, tx_delim_active;
    logic        rd_dp = 1'b0;
    logic [31:0] exp_q[$];
    int          err_count = 0;
    int          n_tests = 0;
    int          seed = 75;
    int          fs_cnt = 0;
    int          fb_cnt = 0;
    int          fe_cnt = 0;

    always #25 hclk = ~hclk;

    rbg_top uut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .spi_sel_n,
        .spi_fb_read, .listen_state, .auto_ack_receive_state,
        .rx_sync_word_valid, .rx_sync_word, .rx_header_valid, .rx_frame_done,
        .rx_fcs_ok, .rx_byte_valid, .rx_byte, .tx_preamble_done, .tx_bit_tick,
        .host_fb_we, .host_fb_addr, .host_fb_wdata, .fb_we, .fb_addr,
        .fb_wdata, .air_wr_en, .buf_protected, .frame_start_irq,
        .frame_end_irq, .tx_delim_bit, .tx_delim_active, .psdu_rate_select
    );

    rbg_air_model air (
        .hclk, .rx_sync_word_valid, .rx_sync_word, .rx_header_valid,
        .rx_frame_done, .rx_fcs_ok, .rx_byte_valid, .rx_byte
    );

    // ---------------------------------------------------------------
    // checking and closing
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // read data watcher, compares against the oldest note
    always @(posedge hclk) begin
        if (rd_dp && hreadyout === 1'b1)
            chk("hrdata", hrdata, exp_q.pop_front());
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
    end

    // pulse counters for start irq, end irq and buffer writes
    always @(posedge hclk) begin
        fs_cnt <= fs_cnt + int'(frame_start_irq === 1'b1);
        fb_cnt <= fb_cnt + int'(fb_we === 1'b1);
        fe_cnt <= fe_cnt + int'(frame_end_irq === 1'b1);
        if (fb_we === 1'b1) begin
            last_fb <= fb_wdata;
            last_fa <= fb_addr;
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        wrap_up();
    end

    // ---------------------------------------------------------------
    // bus and timing helpers
    // ---------------------------------------------------------------
    task automatic ready_edge;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            err_count++;
            wrap_up();
        end
    endtask

    task automatic ahb(input logic wr, input logic [9:0] a,
                       input logic [31:0] wd, input logic [31:0] e);
        if (!wr)
            exp_q.push_back(e);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, a};
        ready_edge();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        ready_edge();
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {spi_fb_read, listen_state, auto_ack_receive_state} = '0;
        {tx_preamble_done, tx_bit_tick, host_fb_we, host_fb_addr} = '0;
        host_fb_wdata = 8'h00;
        spi_sel_n = 1'b1;
        hsize = 3'b010;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(0, rbg_pkg::ADDR_DELIM, 0, 32'ha7);
        ahb(0, rbg_pkg::ADDR_CTRL2, 0, 32'h0);
        ahb(1, rbg_pkg::ADDR_CTRL2, 32'hffffffff, 0);
        ahb(0, rbg_pkg::ADDR_CTRL2, 0, 32'h83);
        chk("rate", psdu_rate_select, 2'h3);
        chk("hresp", hresp, 1'b0);
        ahb(0, 10'h3fc, 0, 32'h0);
        d = 8'($random(seed));
        d[0] = 1'b1; // low nibble kept nonzero
        ahb(1, rbg_pkg::ADDR_DELIM, {24'h0, d}, 0);
        ahb(0, rbg_pkg::ADDR_DELIM, 0, {24'h0, d});
        ahb(1, rbg_pkg::ADDR_CTRL2, 32'h00, 0);
        listen_state <= 1'b1;
        idle(4);
        air.send(d, 2, 1'b1);
        idle(4);
        chk("start", fs_cnt, 1);
        chk("air wr", fb_cnt, 2);
        chk("end", fe_cnt, 1);
        chk("prot off", buf_protected, 1'b0);
        air.send(~d, 2, 1'b1);
        idle(4);
        chk("mismatch", fs_cnt * 10 + fb_cnt, 12);
        ahb(1, rbg_pkg::ADDR_CTRL2, 32'h80, 0);
        air.send(d, 2, 1'b0);
        idle(4);
        chk("bad fcs", buf_protected, 1'b0);
        ahb(1, rbg_pkg::ADDR_IRQ_STAT, 32'hf, 0);
        ahb(1, rbg_pkg::ADDR_IRQ_MASK, 32'h0, 0);
        air.send(d, 3, 1'b1);
        idle(4);
        chk("prot", buf_protected, 1'b1);
        chk("last byte", {fb_cnt[23:0], last_fb}, {24'd7, 8'h12});
        chk("last addr", last_fa, 7'h02);
        chk("masked", irq, 1'b0);
        ahb(0, rbg_pkg::ADDR_IRQ_STAT, 0, 32'hd);
        ahb(1, rbg_pkg::ADDR_IRQ_MASK, 32'h1, 0);
        idle(1);
        chk("irq", irq, 1'b1);
        air.send(d, 2, 1'b1);
        idle(4);
        chk("dropped", {fb_cnt[23:0], 7'h0, buf_protected}, 32'h701);
        @(posedge hclk);
        host_fb_we <= 1'b1;
        host_fb_addr <= 7'h05;
        host_fb_wdata <= 8'h5a;
        @(posedge hclk);
        host_fb_we <= 1'b0;
        idle(3);
        chk("host wr", {fb_cnt[23:0], last_fb}, {24'd8, 8'h5a});
        chk("host addr", last_fa, 7'h05);
        spi_fb_read <= 1'b1;
        spi_sel_n <= 1'b0;
        idle(4);
        spi_sel_n <= 1'b1;
        idle(2);
        spi_fb_read <= 1'b0;
        idle(6);
        chk("sel release", buf_protected, 1'b0);
        ahb(1, rbg_pkg::ADDR_IRQ_STAT, 32'hf, 0);
        ahb(0, rbg_pkg::ADDR_IRQ_STAT, 0, 32'h0);
        chk("irq clear", irq, 1'b0);
        ahb(1, rbg_pkg::ADDR_MODE, 32'h1, 0);
        listen_state <= 1'b0;
        auto_ack_receive_state <= 1'b1;
        idle(4);
        air.send(d, 2, 1'b0);
        idle(4);
        chk("ext prot", buf_protected, 1'b1);
        auto_ack_receive_state <= 1'b0;
        idle(6);
        chk("state release", buf_protected, 1'b0);
        auto_ack_receive_state <= 1'b1;
        idle(4);
        air.send(d, 1, 1'b0);
        idle(4);
        hresetn <= 1'b0;
        idle(2);
        chk("reset prot", buf_protected, 1'b0);
        hresetn <= 1'b1;
        ahb(0, rbg_pkg::ADDR_DELIM, 0, 32'ha7);
        @(posedge hclk);
        tx_preamble_done <= 1'b1;
        @(posedge hclk);
        tx_preamble_done <= 1'b0;
        @(negedge hclk);
        for (int i = 0; i < 8; i++) begin
            chk("tx bit", {tx_delim_active, tx_delim_bit},
                {1'b1, rbg_pkg::DELIM_RESET[i]});
            repeat (6) @(posedge hclk);
            tx_bit_tick <= 1'b1;
            @(posedge hclk);
            tx_bit_tick <= 1'b0;
            @(negedge hclk);
        end
        chk("tx end", tx_delim_active, 1'b0);
        wrap_up();
    end
endmodule

// file: rtl/rbg_pkg.sv
package rbg_pkg;
    // ---------------------------------------------------------------
    // register map, byte addresses (index times four)
    // ---------------------------------------------------------------
    localparam logic [7:0]  IDX_DELIM      = 8'h0b;
    localparam logic [7:0]  IDX_CTRL2      = 8'h0c;
    localparam logic [7:0]  IDX_MODE       = 8'h10;
    localparam logic [7:0]  IDX_STATUS     = 8'h11;
    localparam logic [7:0]  IDX_IRQ_STAT   = 8'h12;
    localparam logic [7:0]  IDX_IRQ_MASK   = 8'h13;
    localparam logic [9:0]  ADDR_DELIM     = {IDX_DELIM, 2'b00};
    localparam logic [9:0]  ADDR_CTRL2     = {IDX_CTRL2, 2'b00};
    localparam logic [9:0]  ADDR_MODE      = {IDX_MODE, 2'b00};
    localparam logic [9:0]  ADDR_STATUS    = {IDX_STATUS, 2'b00};
    localparam logic [9:0]  ADDR_IRQ_STAT  = {IDX_IRQ_STAT, 2'b00};
    localparam logic [9:0]  ADDR_IRQ_MASK  = {IDX_IRQ_MASK, 2'b00};
    // ---------------------------------------------------------------
    // fields and reset values
    // ---------------------------------------------------------------
    localparam int          CTRL2_GUARD_BIT = 7;
    localparam logic [7:0]  DELIM_RESET     = 8'ha7;
    localparam logic [7:0]  CTRL2_RESET     = 8'h00;
    localparam logic [7:0]  CTRL2_WMASK     = 8'h83;
    localparam int          IRQ_PROT_BIT    = 0;
    localparam int          IRQ_DROP_BIT    = 1;
    localparam int          IRQ_START_BIT   = 2;
    localparam int          IRQ_END_BIT     = 3;
    localparam logic [3:0]  IRQ_RESET       = 4'h0;
    localparam int          SYNC_BITS       = 4;
endpackage

// file: rtl/rbg_sync.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// two flop synchroniser, one per bit
// ---------------------------------------------------------------
module rbg_sync #(
    parameter int W = 1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// file: rtl/rbg_top.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ns
// Functional notes
// - in receive states each new frame replaces buffer unless protected
// - protected buffer refuses air frames until buffer read ends, select high
// - basic mode protects a frame only when its check sequence is valid
// - extended mode protects a frame whenever frame end interrupt fires
// - protection acts only with guard bit set in listen or auto-ack state
// - host writes over SPI still change the buffer under protection
// - released by select rising after buffer read, or leaving receive states
// - protection ignores the detection threshold setting
// - delimiter is one octet, two symbols, ending the sync header
// - delimiter used for byte sync only, never stored
// - delimiter sent lsb first straight after last preamble bit
// - delimiter register resets to a7, host may write any octet
// - frame start interrupt only on delimiter match and valid header
// - control bits 6 to 2 reserved, read only, read zero
// - control bits 1 to 0 hold rate select, resets to zero
module rbg_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic        spi_sel_n,
    input  wire logic        spi_fb_read,
    input  wire logic        listen_state,
    input  wire logic        auto_ack_receive_state,
    input  wire logic        rx_sync_word_valid,
    input  wire logic [7:0]  rx_sync_word,
    input  wire logic        rx_header_valid,
    input  wire logic        rx_frame_done,
    input  wire logic        rx_fcs_ok,
    input  wire logic        rx_byte_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        tx_preamble_done,
    input  wire logic        tx_bit_tick,
    input  wire logic        host_fb_we,
    input  wire logic [6:0]  host_fb_addr,
    input  wire logic [7:0]  host_fb_wdata,
    output logic             fb_we,
    output logic      [6:0]  fb_addr,
    output logic      [7:0]  fb_wdata,
    output logic             air_wr_en,
    output logic             buf_protected,
    output logic             frame_start_irq,
    output logic             frame_end_irq,
    output logic             tx_delim_bit,
    output logic             tx_delim_active,
    output logic      [1:0]  psdu_rate_select
);
    // ---------------------------------------------------------------
    // synchronise outside levels
    // ---------------------------------------------------------------
    logic [3:0] raw_in;
    logic [3:0] syn_in;
    logic       sel_n_s;
    logic       fb_rd_s;
    logic       listen_s;
    logic       aack_s;

    assign raw_in = {~spi_sel_n, spi_fb_read, listen_state,
                     auto_ack_receive_state};

    rbg_sync #(.W(rbg_pkg::SYNC_BITS)) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (raw_in),
        .sync_out (syn_in)
    );

    assign sel_n_s  = ~syn_in[3]; // inverted, reset matches idle high
    assign fb_rd_s  = syn_in[2];
    assign listen_s = syn_in[1];
    assign aack_s   = syn_in[0];

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] delim_r;
    logic       guard_en_r;
    logic [1:0] rate_r;
    logic       ext_mode_r;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    logic       prot_active;
    logic       delim_match_r;

    // ---------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ---------------------------------------------------------------
    logic       ap_wr_r;
    logic       ap_rd_r;
    logic [9:0] ap_addr_r;
    logic       take;

    assign take      = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // capture address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_r   <= 1'b0;
            ap_rd_r   <= 1'b0;
            ap_addr_r <= '0;
        end else begin
            ap_wr_r   <= take & hwrite;
            ap_rd_r   <= take & ~hwrite;
            ap_addr_r <= haddr[9:0];
        end
    end

    // read data from flops, unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (take && !hwrite) begin
            case (haddr[9:0])
                rbg_pkg::ADDR_DELIM:    hrdata <= {24'h0, delim_r};
                rbg_pkg::ADDR_CTRL2:    hrdata <= {24'h0, guard_en_r,
                                                   5'h00, rate_r};
                rbg_pkg::ADDR_MODE:     hrdata <= {31'h0, ext_mode_r};
                rbg_pkg::ADDR_STATUS:   hrdata <= {30'h0, prot_active,
                                                   buf_protected};
                rbg_pkg::ADDR_IRQ_STAT: hrdata <= {28'h0, irq_stat_r};
                rbg_pkg::ADDR_IRQ_MASK: hrdata <= {28'h0, irq_mask_r};
                default:                hrdata <= '0;
            endcase
        end
    end

    // configuration writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            delim_r    <= rbg_pkg::DELIM_RESET;
            guard_en_r <= rbg_pkg::CTRL2_RESET[rbg_pkg::CTRL2_GUARD_BIT];
            rate_r     <= rbg_pkg::CTRL2_RESET[1:0];
            ext_mode_r <= 1'b0;
            irq_mask_r <= rbg_pkg::IRQ_RESET;
        end else if (ap_wr_r) begin
            case (ap_addr_r)
                rbg_pkg::ADDR_DELIM:    delim_r <= hwdata[7:0];
                rbg_pkg::ADDR_CTRL2: begin
                    guard_en_r <= hwdata[rbg_pkg::CTRL2_GUARD_BIT];
                    rate_r     <= hwdata[1:0];
                end
                rbg_pkg::ADDR_MODE:     ext_mode_r <= hwdata[0];
                rbg_pkg::ADDR_IRQ_MASK: irq_mask_r <= hwdata[3:0];
                default:                ;
            endcase
        end
    end

    assign psdu_rate_select = rate_r;

    // ---------------------------------------------------------------
    // protection control
    // ---------------------------------------------------------------
    logic in_rx;
    logic sel_n_d_r;
    logic fb_rd_r;
    logic release_ev;
    logic frame_ok;
    logic protect_ev;
    logic drop_ev;
    logic frame_busy_r;

    assign in_rx = listen_s | aack_s;
    // threshold setting is not an input here at all
    assign prot_active = guard_en_r & in_rx;

    // remember a buffer read within the current select frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_n_d_r <= 1'b1;
            fb_rd_r   <= 1'b0;
        end else begin
            sel_n_d_r <= sel_n_s;
            if (sel_n_s && !sel_n_d_r)
                fb_rd_r <= 1'b0;
            else if (!sel_n_s && fb_rd_s)
                fb_rd_r <= 1'b1;
        end
    end

    assign release_ev = (sel_n_s & ~sel_n_d_r & fb_rd_r) | ~prot_active;

    // basic mode needs good check sequence, extended on every frame end
    assign frame_ok = ext_mode_r ? 1'b1 : rx_fcs_ok;

    // set on completion only, release via select or state change
    assign protect_ev = rx_frame_done & frame_ok & prot_active
                        & ~buf_protected & frame_busy_r;
    assign drop_ev    = rx_frame_done & buf_protected;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_protected <= 1'b0;
        end else if (release_ev) begin
            buf_protected <= 1'b0;
        end else if (protect_ev) begin
            buf_protected <= 1'b1;
        end
    end

    // track a frame in progress from the air
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            frame_busy_r <= 1'b0;
        else if (rx_frame_done)
            frame_busy_r <= 1'b0;
        else if (rx_header_valid && delim_match_r)
            frame_busy_r <= 1'b1;
    end

    // ---------------------------------------------------------------
    // delimiter match and frame start
    // ---------------------------------------------------------------
    // octet compared for byte sync only, never written out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            delim_match_r <= 1'b0;
        else if (rx_sync_word_valid)
            delim_match_r <= (rx_sync_word == delim_r);
        else if (rx_frame_done)
            delim_match_r <= 1'b0;
    end

    // start pulse on match plus valid header
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_start_irq <= 1'b0;
            frame_end_irq   <= 1'b0;
        end else begin
            frame_start_irq <= rx_header_valid & delim_match_r;
            frame_end_irq   <= rx_frame_done & frame_busy_r;
        end
    end

    // ---------------------------------------------------------------
    // frame buffer write path
    // ---------------------------------------------------------------
    logic [6:0] air_ptr_r;

    // air writes gated while protected, whole frame dropped
    assign air_wr_en = ~buf_protected & frame_busy_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            air_ptr_r <= '0;
        else if (rx_header_valid)
            air_ptr_r <= '0;
        else if (rx_byte_valid && air_wr_en && !host_fb_we)
            air_ptr_r <= air_ptr_r + 7'h01;
    end

    // host writes always pass, protection or not
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fb_we    <= 1'b0;
            fb_addr  <= '0;
            fb_wdata <= '0;
        end else if (host_fb_we) begin
            fb_we    <= 1'b1;
            fb_addr  <= host_fb_addr;
            fb_wdata <= host_fb_wdata;
        end else begin
            fb_we    <= rx_byte_valid & air_wr_en;
            fb_addr  <= air_ptr_r;
            fb_wdata <= rx_byte;
        end
    end

    // ---------------------------------------------------------------
    // transmit delimiter serialiser
    // ---------------------------------------------------------------
    logic [7:0] tx_sh_r;
    logic [3:0] tx_cnt_r;

    // lsb first, starting right after the preamble
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_sh_r  <= '0;
            tx_cnt_r <= '0;
        end else if (tx_preamble_done) begin
            tx_sh_r  <= delim_r;
            tx_cnt_r <= 4'h8;
        end else if (tx_bit_tick && tx_cnt_r != 4'h0) begin
            tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
            tx_cnt_r <= tx_cnt_r - 4'h1;
        end
    end

    assign tx_delim_bit    = tx_sh_r[0];
    assign tx_delim_active = (tx_cnt_r != 4'h0);

    // ---------------------------------------------------------------
    // interrupts, set wins over write-one clear
    // ---------------------------------------------------------------
    logic [3:0] irq_set;
    logic [3:0] irq_clr;

    assign irq_set = {frame_end_irq, frame_start_irq, drop_ev, protect_ev};
    assign irq_clr = (ap_wr_r && ap_addr_r == rbg_pkg::ADDR_IRQ_STAT)
                     ? hwdata[3:0] : 4'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq_stat_r <= rbg_pkg::IRQ_RESET;
        else
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_prot_needs_guard: assert property (
        @(posedge hclk) disable iff (!hresetn)
        buf_protected |-> $past(guard_en_r))
        else $error("protected without guard enable");
    a_air_blocked: assert property (
        @(posedge hclk) disable iff (!hresetn)
        buf_protected && !host_fb_we |=> !fb_we)
        else $error("air write while protected");
    a_host_passes: assert property (
        @(posedge hclk) disable iff (!hresetn)
        host_fb_we |=> fb_we && fb_wdata == $past(host_fb_wdata))
        else $error("host write lost");
    a_basic_fcs: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rx_frame_done && !rx_fcs_ok && !ext_mode_r && !buf_protected
        |=> !buf_protected)
        else $error("bad frame protected");
    a_ext_end: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rx_frame_done && ext_mode_r && prot_active && !buf_protected
        && frame_busy_r |=> buf_protected)
        else $error("extended frame not protected");
    a_sel_release: assert property (
        @(posedge hclk) disable iff (!hresetn)
        buf_protected && sel_n_s && !sel_n_d_r && fb_rd_r
        |=> !buf_protected)
        else $error("no release on select");
    a_start_match: assert property (
        @(posedge hclk) disable iff (!hresetn)
        frame_start_irq |-> $past(delim_match_r) && $past(rx_header_valid))
        else $error("start without match");
    a_tx_lsb: assert property (
        @(posedge hclk) disable iff (!hresetn)
        tx_preamble_done |=> tx_delim_bit == $past(delim_r[0])
                             && tx_cnt_r == 4'h8)
        else $error("delimiter not lsb first");
    a_ctrl_resv: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ap_rd_r && ap_addr_r == rbg_pkg::ADDR_CTRL2 |-> hrdata[6:2] == 5'h00)
        else $error("reserved bits nonzero");
endmodule
